// [hw/ddr_burst4_sram_bus_port.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ddr_burst4_defines.svh"

module ddr_burst4_sram_bus_port #(
	parameter ddr_burst4_pkg::width_cfg_t WIDTH_CFG = ddr_burst4_pkg::CFG_X36,
	parameter int                         MEM_AW    = 10
) (
	input  wire logic                   mclk_in,
	input  wire logic                   rst_b_in,
	input  wire logic                   k_clk_in,
	input  wire logic                   dll_bypass_n_in,
	input  wire logic [`ADDR_W-1:0]     sync_address_in,
	input  wire logic                   cycle_load_n_in,
	input  wire logic                   read_write_sel_in,
	input  wire logic [`NUM_BYTES-1:0]  byte_write_enable_n_in,
	input  wire logic [`DQ_W-1:0]       shared_data_pins_in,
	output logic      [`DQ_W-1:0]       shared_data_pins_out,
	output logic      [`DQ_W-1:0]       shared_data_pins_oe_out,
	output logic                        echo_clock_true_out,
	output logic                        echo_clock_comp_out,
	output logic                        read_valid_flag_out,
	output logic                        dll_locked_out
);
	import ddr_burst4_pkg::*;

	localparam int MEM_WORDS = (1 << (MEM_AW + 2));

	// ------------------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------------------
	function automatic logic [MEM_AW+1:0] mem_index(
		input logic [`ADDR_W-1:0]     addr,
		input logic [`BEAT_SEL_W-1:0] beat
	);
		mem_index = {addr[MEM_AW-1:0], beat};
	endfunction

	function automatic logic [`DQ_W-1:0] lane_mask(input width_cfg_t cfg);
		lane_mask = {`DQ_W{1'b1}};
		if (cfg == CFG_X18) begin
			lane_mask = {{(`DQ_W-`NARROW_LANES){1'b0}}, {`NARROW_LANES{1'b1}}};
		end
	endfunction

	function automatic logic [`DQ_W-1:0] merge_bytes(
		input logic [`DQ_W-1:0]      old_word,
		input logic [`DQ_W-1:0]      new_word,
		input logic [`NUM_BYTES-1:0] bw_n,
		input width_cfg_t            cfg
	);
		merge_bytes = old_word;
		for (int i = 0; i < `NUM_BYTES; i++) begin
			if (!bw_n[i] && (cfg == CFG_X36 || i < `NARROW_BYTES)) begin
				merge_bytes[i*`BYTE_W +: `BYTE_W] = new_word[i*`BYTE_W +: `BYTE_W];
			end
		end
	endfunction

	// ------------------------------------------------------------------------
	// DLL control on the system clock
	// ------------------------------------------------------------------------
	logic                   dll_meta_reg;
	logic                   dll_pin_reg;
	dll_state_t             dll_state_reg;
	dll_state_t             dll_state_next;
	logic [`LOCK_CNT_W-1:0] lock_cnt_reg;
	logic                   full_lat_reg;
	logic                   dll_locked_reg;

	always_ff @(posedge mclk_in) begin
		dll_meta_reg <= dll_bypass_n_in;
		dll_pin_reg  <= dll_meta_reg;
	end

	always_comb begin
		dll_state_next = dll_state_reg;
		case (dll_state_reg)
			DLL_BYPASS: begin
				if (dll_pin_reg) begin
					dll_state_next = DLL_LOCKING;
				end
			end
			DLL_LOCKING: begin
				if (!dll_pin_reg) begin
					dll_state_next = DLL_BYPASS;
				end else if (lock_cnt_reg == `LOCK_CNT_W'(`DLL_LOCK_CYCLES - 1)) begin
					dll_state_next = DLL_LOCKED;
				end
			end
			DLL_LOCKED: begin
				if (!dll_pin_reg) begin
					dll_state_next = DLL_BYPASS;
				end
			end
			default: begin
				dll_state_next = DLL_BYPASS;
			end
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			dll_state_reg <= DLL_BYPASS;
		end else begin
			dll_state_reg <= dll_state_next;
		end
	end

	// Lock history is thrown away whenever the loop is bypassed.
	always_ff @(posedge mclk_in) begin
		if (!rst_b_in || dll_state_reg != DLL_LOCKING) begin
			lock_cnt_reg <= '0;
		end else begin
			lock_cnt_reg <= lock_cnt_reg + `LOCK_CNT_W'(1);
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			full_lat_reg   <= 1'b0;
			dll_locked_reg <= 1'b0;
		end else begin
			full_lat_reg   <= (dll_state_next != DLL_BYPASS);
			dll_locked_reg <= (dll_state_next == DLL_LOCKED);
		end
	end

	assign dll_locked_out = dll_locked_reg;

	// ------------------------------------------------------------------------
	// Crossings into the input clock domain
	// ------------------------------------------------------------------------
	logic k_rst_meta_reg;
	logic k_rst_b_reg;
	logic lat_meta_reg;
	logic lat_full_reg;

	always_ff @(posedge k_clk_in) begin
		k_rst_meta_reg <= rst_b_in;
		k_rst_b_reg    <= k_rst_meta_reg;
		lat_meta_reg   <= full_lat_reg;
		lat_full_reg   <= lat_meta_reg;
	end

	// ------------------------------------------------------------------------
	// Command pipeline on the true clock rise
	// ------------------------------------------------------------------------
	logic                 rd_cmd;
	logic                 wr_cmd;
	logic                 rd_vld_reg  [1:`RD_PIPE_LEN];
	logic [`ADDR_W-1:0]   rd_addr_reg [1:`RD_PIPE_LEN];
	logic                 wr_vld_reg  [1:`WR_PIPE_LEN];
	logic [`ADDR_W-1:0]   wr_addr_reg [1:`WR_PIPE_LEN];

	assign rd_cmd = !cycle_load_n_in && read_write_sel_in;
	assign wr_cmd = !cycle_load_n_in && !read_write_sel_in;

	always_ff @(posedge k_clk_in) begin
		if (!k_rst_b_reg) begin
			for (int i = 1; i <= `RD_PIPE_LEN; i++) begin
				rd_vld_reg[i]  <= 1'b0;
				rd_addr_reg[i] <= '0;
			end
			for (int i = 1; i <= `WR_PIPE_LEN; i++) begin
				wr_vld_reg[i]  <= 1'b0;
				wr_addr_reg[i] <= '0;
			end
		end else begin
			rd_vld_reg[1]  <= rd_cmd;
			wr_vld_reg[1]  <= wr_cmd;
			// Address only advances on a loaded cycle, so a no-op leaves it alone.
			if (!cycle_load_n_in) begin
				rd_addr_reg[1] <= sync_address_in;
				wr_addr_reg[1] <= sync_address_in;
			end
			for (int i = 2; i <= `RD_PIPE_LEN; i++) begin
				rd_vld_reg[i]  <= rd_vld_reg[i-1];
				rd_addr_reg[i] <= rd_addr_reg[i-1];
			end
			for (int i = 2; i <= `WR_PIPE_LEN; i++) begin
				wr_vld_reg[i]  <= wr_vld_reg[i-1];
				wr_addr_reg[i] <= wr_addr_reg[i-1];
			end
		end
	end

	// ------------------------------------------------------------------------
	// Storage and write path
	// ------------------------------------------------------------------------
	logic [`DQ_W-1:0]      mem [0:MEM_WORDS-1];
	logic [`DQ_W-1:0]      wbeat0_reg;
	logic [`DQ_W-1:0]      wbeat2_reg;
	logic [`DQ_W-1:0]      wbeat1_reg;
	logic [`NUM_BYTES-1:0] wbw0_reg;
	logic [`NUM_BYTES-1:0] wbw2_reg;
	logic [`NUM_BYTES-1:0] wbw1_reg;

	// Beats 0 and 2 arrive on the true clock rise, one and two cycles after the command.
	always_ff @(posedge k_clk_in) begin
		if (!k_rst_b_reg) begin
			wbeat0_reg <= '0;
			wbeat2_reg <= '0;
			wbw0_reg   <= '1;
			wbw2_reg   <= '1;
		end else begin
			if (wr_vld_reg[1]) begin
				wbeat0_reg <= shared_data_pins_in;
				wbw0_reg   <= byte_write_enable_n_in;
			end
			if (wr_vld_reg[2]) begin
				wbeat2_reg <= shared_data_pins_in;
				wbw2_reg   <= byte_write_enable_n_in;
			end
		end
	end

	// Beats 1 and 3 arrive on the complement rise; the whole burst lands in the
	// array with beat 3, so a read issued two cycles later already sees it.
	always_ff @(negedge k_clk_in) begin
		if (!k_rst_b_reg) begin
			wbeat1_reg <= '0;
			wbw1_reg   <= '1;
		end else begin
			if (wr_vld_reg[2]) begin
				wbeat1_reg <= shared_data_pins_in;
				wbw1_reg   <= byte_write_enable_n_in;
			end
			if (wr_vld_reg[3]) begin
				mem[mem_index(wr_addr_reg[3], 2'h0)] <=
					merge_bytes(mem[mem_index(wr_addr_reg[3], 2'h0)], wbeat0_reg, wbw0_reg, WIDTH_CFG);
				mem[mem_index(wr_addr_reg[3], 2'h1)] <=
					merge_bytes(mem[mem_index(wr_addr_reg[3], 2'h1)], wbeat1_reg, wbw1_reg, WIDTH_CFG);
				mem[mem_index(wr_addr_reg[3], 2'h2)] <=
					merge_bytes(mem[mem_index(wr_addr_reg[3], 2'h2)], wbeat2_reg, wbw2_reg, WIDTH_CFG);
				mem[mem_index(wr_addr_reg[3], 2'h3)] <=
					merge_bytes(mem[mem_index(wr_addr_reg[3], 2'h3)], shared_data_pins_in,
						byte_write_enable_n_in, WIDTH_CFG);
			end
		end
	end

	// ------------------------------------------------------------------------
	// Read path, true clock rise half
	// ------------------------------------------------------------------------
	logic [`DQ_W-1:0] pos_dq_reg;
	logic             pos_oe_reg;
	logic             pos_vld_reg;
	logic             pos_tog_reg;

	always_ff @(posedge k_clk_in) begin
		if (!k_rst_b_reg) begin
			pos_dq_reg  <= '0;
			pos_oe_reg  <= 1'b0;
			pos_vld_reg <= 1'b0;
		end else if (lat_full_reg) begin
			pos_oe_reg  <= rd_vld_reg[3] || rd_vld_reg[4];
			pos_vld_reg <= rd_vld_reg[2] || rd_vld_reg[3];
			if (rd_vld_reg[3]) begin
				pos_dq_reg <= mem[mem_index(rd_addr_reg[3], 2'h1)];
			end else begin
				pos_dq_reg <= mem[mem_index(rd_addr_reg[4], 2'h3)];
			end
		end else begin
			pos_oe_reg  <= rd_vld_reg[1] || rd_vld_reg[2];
			pos_vld_reg <= rd_vld_reg[1] || rd_vld_reg[2];
			if (rd_vld_reg[1]) begin
				pos_dq_reg <= mem[mem_index(rd_addr_reg[1], 2'h0)];
			end else begin
				pos_dq_reg <= mem[mem_index(rd_addr_reg[2], 2'h2)];
			end
		end
	end

	// ------------------------------------------------------------------------
	// Read path, complement clock rise half
	// ------------------------------------------------------------------------
	logic [`DQ_W-1:0] neg_dq_reg;
	logic             neg_oe_reg;
	logic             neg_vld_reg;
	logic             neg_tog_reg;

	always_ff @(negedge k_clk_in) begin
		if (!k_rst_b_reg) begin
			neg_dq_reg  <= '0;
			neg_oe_reg  <= 1'b0;
			neg_vld_reg <= 1'b0;
		end else if (lat_full_reg) begin
			neg_oe_reg  <= rd_vld_reg[3] || rd_vld_reg[4];
			neg_vld_reg <= rd_vld_reg[3] || rd_vld_reg[4];
			if (rd_vld_reg[3]) begin
				neg_dq_reg <= mem[mem_index(rd_addr_reg[3], 2'h0)];
			end else begin
				neg_dq_reg <= mem[mem_index(rd_addr_reg[4], 2'h2)];
			end
		end else begin
			neg_oe_reg  <= rd_vld_reg[2] || rd_vld_reg[3];
			neg_vld_reg <= rd_vld_reg[1] || rd_vld_reg[2];
			if (rd_vld_reg[2]) begin
				neg_dq_reg <= mem[mem_index(rd_addr_reg[2], 2'h1)];
			end else begin
				neg_dq_reg <= mem[mem_index(rd_addr_reg[3], 2'h3)];
			end
		end
	end

	// ------------------------------------------------------------------------
	// Echo clocks and pin drive
	// ------------------------------------------------------------------------
	logic echo_phase;

	// A free-running toggle pair has no known start value, so the pair rests
	// during reset; the echo clocks start on the first rise after it.
	always_ff @(posedge k_clk_in) begin
		if (!k_rst_b_reg) begin
			pos_tog_reg <= 1'b0;
		end else begin
			pos_tog_reg <= !neg_tog_reg;
		end
	end

	always_ff @(negedge k_clk_in) begin
		if (!k_rst_b_reg) begin
			neg_tog_reg <= 1'b0;
		end else begin
			neg_tog_reg <= pos_tog_reg;
		end
	end

	// Data, flag and echo all select on the same phase, so their edges match;
	// the price is a half-cycle mux after the flops instead of a single flop.
	assign echo_phase              = pos_tog_reg ^ neg_tog_reg;
	assign echo_clock_true_out     = echo_phase;
	assign echo_clock_comp_out     = !echo_phase;
	assign shared_data_pins_out    = echo_phase ? pos_dq_reg : neg_dq_reg;
	assign shared_data_pins_oe_out = (echo_phase ? pos_oe_reg : neg_oe_reg) ? lane_mask(WIDTH_CFG) : '0;
	assign read_valid_flag_out     = echo_phase ? pos_vld_reg : neg_vld_reg;

endmodule
`default_nettype wire

// [hw/ddr_burst4_defines.svh]
`ifndef DDR_BURST4_DEFINES_SVH
`define DDR_BURST4_DEFINES_SVH

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define DQ_W            36
`define NARROW_LANES    18
`define ADDR_W          19
`define BYTE_W          9
`define NUM_BYTES       4
`define NARROW_BYTES    2
`define BEAT_SEL_W      2

// ----------------------------------------------------------------------------
// Burst and pipeline depths
// ----------------------------------------------------------------------------
`define BURST_LEN       4
`define RD_PIPE_LEN     4
`define WR_PIPE_LEN     3

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define DLL_LOCK_CYCLES 2048
`define LOCK_CNT_W      12

`endif

// [hw/ddr_burst4_pkg.sv]
package ddr_burst4_pkg;

	typedef enum logic {
		CFG_X18 = 1'b0,
		CFG_X36 = 1'b1
	} width_cfg_t;

	typedef enum logic [1:0] {
		DLL_BYPASS  = 2'b00,
		DLL_LOCKING = 2'b01,
		DLL_LOCKED  = 2'b10
	} dll_state_t;

endpackage

// [dv/ddr_burst4_port_checker_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ddr_burst4_defines.svh"
module ddr_burst4_port_checker (
	input wire logic             mclk_in,
	input wire logic             rst_b_in,
	input wire logic             k_clk_in,
	input wire logic             dll_bypass_n_in,
	input wire logic [`DQ_W-1:0] shared_data_pins_oe_out,
	input wire logic             echo_clock_true_out,
	input wire logic             echo_clock_comp_out,
	input wire logic             read_valid_flag_out,
	input wire logic             dll_locked_out
);
	// Counts mclk cycles with the DLL pin high; saturates so it never wraps.
	logic [12:0] hi_cnt_reg;
	wire logic   oe0 = shared_data_pins_oe_out[0];
	// The device sees reset through a two-stage sync on the link clock, so link checks wait three rises.
	logic [1:0]  k_ok_reg;
	wire logic   k_off = !rst_b_in || (k_ok_reg != 2'h3);
	always_ff @(posedge k_clk_in) begin
		if (!rst_b_in) k_ok_reg <= 2'h0;
		else if (k_ok_reg != 2'h3) k_ok_reg <= k_ok_reg + 2'h1;
	end
	always_ff @(posedge mclk_in) begin
		if (!rst_b_in || !dll_bypass_n_in) hi_cnt_reg <= '0;
		else if (!hi_cnt_reg[12]) hi_cnt_reg <= hi_cnt_reg + 13'h1;
	end
	property p_echo_pair;
		@(edge k_clk_in) disable iff (k_off) echo_clock_comp_out == !echo_clock_true_out;
	endproperty
	a_echo_pair: assert property (p_echo_pair) else $error("echo clocks not complementary");
	property p_echo_rise;
		@(posedge k_clk_in) disable iff (k_off) !echo_clock_true_out;
	endproperty
	a_echo_rise: assert property (p_echo_rise) else $error("echo clock high before rise");
	property p_echo_fall;
		@(negedge k_clk_in) disable iff (k_off) echo_clock_true_out;
	endproperty
	a_echo_fall: assert property (p_echo_fall) else $error("echo clock low before fall");
	property p_oe_lanes;
		@(edge k_clk_in) disable iff (k_off) (&shared_data_pins_oe_out[17:0]) || !(|shared_data_pins_oe_out[17:0]);
	endproperty
	a_oe_lanes: assert property (p_oe_lanes) else $error("low lanes driven unevenly");
	property p_oe_four;
		@(edge k_clk_in) disable iff (k_off) $rose(oe0) |-> oe0[*4];
	endproperty
	a_oe_four: assert property (p_oe_four) else $error("burst shorter than four beats");
	property p_valid_lead;
		@(edge k_clk_in) disable iff (k_off) $rose(oe0) |-> read_valid_flag_out && $past(read_valid_flag_out);
	endproperty
	a_valid_lead: assert property (p_valid_lead) else $error("valid flag not ahead of data");
	property p_valid_fall;
		@(edge k_clk_in) disable iff (k_off) $fell(read_valid_flag_out) |-> oe0 ##1 (!oe0 && !read_valid_flag_out);
	endproperty
	a_valid_fall: assert property (p_valid_fall) else $error("valid flag fell at wrong beat");
	property p_lock_clear;
		@(posedge mclk_in) disable iff (!rst_b_in) !dll_bypass_n_in[*4] |=> !dll_locked_out;
	endproperty
	a_lock_clear: assert property (p_lock_clear) else $error("lock kept while bypassed");
	property p_lock_early;
		@(posedge mclk_in) disable iff (!rst_b_in) $rose(dll_locked_out) |-> hi_cnt_reg >= `DLL_LOCK_CYCLES;
	endproperty
	a_lock_early: assert property (p_lock_early) else $error("lock before lock time");
	property p_lock_late;
		@(posedge mclk_in) disable iff (!rst_b_in) hi_cnt_reg == `DLL_LOCK_CYCLES + 8 |-> dll_locked_out;
	endproperty
	a_lock_late: assert property (p_lock_late) else $error("lock not reached");
endmodule
bind ddr_burst4_sram_bus_port ddr_burst4_port_checker i_chk (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
	.k_clk_in(k_clk_in), .dll_bypass_n_in(dll_bypass_n_in), .shared_data_pins_oe_out(shared_data_pins_oe_out),
	.echo_clock_true_out(echo_clock_true_out), .echo_clock_comp_out(echo_clock_comp_out),
	.read_valid_flag_out(read_valid_flag_out), .dll_locked_out(dll_locked_out));
`default_nettype wire

// [dv/ddr_burst4_ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ddr_burst4_defines.svh"
// The complement clock is the falling edge of the single link clock, so it is exactly half a period off.
module ddr_burst4_ctrl_model (
	input wire logic               k_clk_in,
	input wire logic [`DQ_W-1:0]   dq_in,
	input wire logic [`DQ_W-1:0]   dev_oe_in,
	input wire logic               valid_in,
	output logic                   cycle_load_n_out,
	output logic                   read_write_sel_out,
	output logic [`ADDR_W-1:0]     sync_address_out,
	output logic [3:0]             byte_write_enable_n_out,
	output logic [`DQ_W-1:0]       dq_out,
	output logic                   dq_oe_out
);
	initial begin
		cycle_load_n_out = 1'b1;
		read_write_sel_out = 1'b1;
		sync_address_out = '0;
		byte_write_enable_n_out = 4'hf;
		dq_out = '0;
		dq_oe_out = 1'b0;
	end
	// Address and direction are scrambled once unloaded, so a device that samples them anyway shows it.
	task automatic issue(input logic rd, input logic [`ADDR_W-1:0] a);
		@(negedge k_clk_in);
		cycle_load_n_out = 1'b0;
		read_write_sel_out = rd;
		sync_address_out = a;
		@(posedge k_clk_in);
		#1;
		cycle_load_n_out = 1'b1;
		read_write_sel_out = ~rd;
		sync_address_out = ~a;
	endtask
	task automatic write_burst(input logic [`ADDR_W-1:0] a, input logic [`DQ_W-1:0] w [4], input logic [3:0] bw [4]);
		issue(1'b0, a);
		for (int b = 0; b < 4; b++) begin
			@(edge k_clk_in);
			#1;
			dq_oe_out = 1'b1;
			dq_out = w[b];
			byte_write_enable_n_out = bw[b];
		end
		@(edge k_clk_in);
		#1;
		dq_oe_out = 1'b0;
		byte_write_enable_n_out = 4'hf;
	endtask
	task automatic read_burst(input logic [`ADDR_W-1:0] a, input int hl, output logic [`DQ_W-1:0] d [4],
		output logic [4:0] v, output logic [4:0] o);
		issue(1'b1, a);
		repeat (hl - 1) @(edge k_clk_in);
		#8;
		v[0] = valid_in;
		for (int b = 0; b < 4; b++) begin
			@(edge k_clk_in);
			#8;
			d[b] = dq_in;
			v[b+1] = valid_in;
			o[b] = &dev_oe_in;
		end
		@(edge k_clk_in);
		#8;
		o[4] = |dev_oe_in;
	endtask
endmodule
`default_nettype wire

// [dv/tb_ddr_burst4_sram_bus_port.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ddr_burst4_defines.svh"
module tb_ddr_burst4_sram_bus_port;
	import ddr_burst4_pkg::*;
	logic               mclk_in = 1'b0;
	logic               k_clk_in = 1'b0;
	logic               rst_b_in = 1'b0;
	logic               dll_bypass_n_in = 1'b0;
	logic               ld_n, rw_sel, c_oe, rvalid, echo_t, echo_c, locked;
	logic [`ADDR_W-1:0] addr;
	logic [3:0]         bw_n;
	logic [`DQ_W-1:0]   c_dq, d_dq, d_oe, dq_wire;
	logic [`DQ_W-1:0]   exp_mem [int];
	int                 fail_count = 0;
	int                 cmp_count = 0;
	// A released bus shows the inverse of the controller's last driven value, not a convenient stale one.
	assign dq_wire = (d_oe & d_dq) | (~d_oe & (c_oe ? c_dq : ~c_dq));
	always #20 mclk_in = ~mclk_in;
	always #16 k_clk_in = ~k_clk_in;
	ddr_burst4_sram_bus_port i_dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .k_clk_in(k_clk_in),
		.dll_bypass_n_in(dll_bypass_n_in), .sync_address_in(addr), .cycle_load_n_in(ld_n),
		.read_write_sel_in(rw_sel), .byte_write_enable_n_in(bw_n), .shared_data_pins_in(dq_wire),
		.shared_data_pins_out(d_dq), .shared_data_pins_oe_out(d_oe), .echo_clock_true_out(echo_t),
		.echo_clock_comp_out(echo_c), .read_valid_flag_out(rvalid), .dll_locked_out(locked));
	ddr_burst4_ctrl_model i_ctrl (.k_clk_in(k_clk_in), .dq_in(dq_wire), .dev_oe_in(d_oe), .valid_in(rvalid),
		.cycle_load_n_out(ld_n), .read_write_sel_out(rw_sel), .sync_address_out(addr),
		.byte_write_enable_n_out(bw_n), .dq_out(c_dq), .dq_oe_out(c_oe));
	task automatic check(input logic [`DQ_W-1:0] seen, input logic [`DQ_W-1:0] exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t %s: %h expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [`ADDR_W-1:0] a, input logic [8:0] s, input logic [3:0] bw [4]);
		logic [`DQ_W-1:0] w [4];
		logic [`DQ_W-1:0] m;
		for (int b = 0; b < 4; b++) begin
			w[b] = {4{s ^ 9'(b)}};
			m = exp_mem.exists({a[9:0], 2'(b)}) ? exp_mem[{a[9:0], 2'(b)}] : 'x;
			for (int i = 0; i < 4; i++) if (!bw[b][i]) m[9*i+:9] = w[b][9*i+:9];
			exp_mem[{a[9:0], 2'(b)}] = m;
		end
		i_ctrl.write_burst(a, w, bw);
	endtask
	task automatic rd(input logic [`ADDR_W-1:0] a, input int hl);
		logic [`DQ_W-1:0] d [4];
		logic [4:0]       v, o;
		i_ctrl.read_burst(a, hl, d, v, o);
		for (int b = 0; b < 4; b++) check(d[b], exp_mem[{a[9:0], 2'(b)}], "read beat");
		check(36'(v), 36'h0f, "valid flag per half");
		check(36'(o), 36'h0f, "drive window");
	endtask
	task automatic t_bypass_rw;
		logic [3:0] bw [4] = '{4'h0, 4'h0, 4'h0, 4'h0};
		wr(19'h40403, 9'h1a5, bw);
		rd(19'h40403, 2);
		$display("bypass write and read done");
	endtask
	task automatic t_byte_lanes;
		logic [3:0] bw [4] = '{4'he, 4'hd, 4'hb, 4'h7};
		wr(19'h00403, 9'h05a, bw);
		rd(19'h00403, 2);
		$display("byte lanes done");
	endtask
	task automatic t_no_load;
		repeat (12) begin
			@(edge k_clk_in);
			#8;
			check(d_oe, '0, "drive while unloaded");
		end
		$display("unloaded cycles done");
	endtask
	task automatic t_dll;
		logic [3:0] bw [4] = '{4'h0, 4'h0, 4'h0, 4'h0};
		int         n = 0;
		@(negedge mclk_in);
		dll_bypass_n_in = 1'b1;
		while (locked !== 1'b1 && n < 3000) begin
			@(negedge mclk_in);
			n++;
		end
		check(36'(n >= 2048 && n <= 2058), 36'h1, "lock time");
		rd(19'h00403, 5);
		wr(19'h0012c, 9'h133, bw);
		rd(19'h0012c, 5);
		@(negedge mclk_in);
		dll_bypass_n_in = 1'b0;
		repeat (5) @(negedge mclk_in);
		check(36'(locked), 36'h0, "lock dropped");
		rd(19'h0012c, 2);
		$display("delay loop modes done");
	endtask
	initial begin
		repeat (4) @(negedge mclk_in);
		check(d_oe, '0, "drive in reset");
		check(36'(rvalid), 36'h0, "valid in reset");
		repeat (4) @(negedge mclk_in);
		rst_b_in = 1'b1;
		repeat (10) @(posedge k_clk_in);
		t_bypass_rw();
		t_byte_lanes();
		t_no_load();
		t_dll();
		wrap_up();
	end
	initial begin
		#400000;
		fail_count++;
		$display("ERROR %0t watchdog expired", $time);
		wrap_up();
	end
endmodule
`default_nettype wire
